// File: design/clock_select_defines.vh
// Register map, field positions, reset values and counts of the main clock controller
`ifndef CLOCK_SELECT_DEFINES_VH
`define CLOCK_SELECT_DEFINES_VH

// Register offsets
`define OFS_MAIN_SOURCE_CTRL   5'h00
`define OFS_PRESCALE_CTRL      5'h01
`define OFS_SETTINGS_LOCK      5'h02
`define OFS_CLOCK_STATE        5'h03
`define OFS_FAST_OSC_CTRL      5'h10
`define OFS_FAST_OSC_FREQ_TRIM 5'h11
`define OFS_FAST_OSC_TEMP_TRIM 5'h12
`define OFS_SLOW_OSC_CTRL      5'h18
`define OFS_CRYSTAL_OSC_CTRL   5'h1C

// Reset values
`define RST_MAIN_SOURCE_CTRL 8'h00
`define RST_PRESCALE_CTRL    8'h11
`define RST_CLOCK_STATE      8'h00
`define RST_OSC_CTRL         8'h00

// Field positions
`define BIT_CLOCK_PIN_EN   7
`define BIT_PRESCALE_EN    0
`define BIT_LOCK           0
`define BIT_RUN_STANDBY    1
`define BIT_XTAL_ENABLE    0
`define BIT_XTAL_SEL       2
`define BIT_SWITCHING      0
`define BIT_FUSE_LOCK      7
`define DIV_MSB            4
`define DIV_LSB            1
`define SEL_MSB            1
`define SEL_LSB            0
`define STABLE_MSB         7
`define STABLE_LSB         4
`define XTAL_CSUT_MSB      5
`define XTAL_CSUT_LSB      4

// Write masks
`define MASK_MAIN_SOURCE 8'h83
`define MASK_PRESCALE    8'h1F
`define MASK_RUN_STANDBY 8'h02
`define MASK_XTAL_CTRL   8'h37
`define MASK_XTAL_LOCKED 8'h03
`define MASK_FREQ_TRIM   8'h7F
`define MASK_TEMP_TRIM   8'h0F

// Main source select codes
`define SRC_FAST    2'h0
`define SRC_ULP     2'h1
`define SRC_CRYSTAL 2'h2
`define SRC_EXT     2'h3

// Divider codes and ratios
`define DIV_CODE_2  4'h0
`define DIV_CODE_4  4'h1
`define DIV_CODE_8  4'h2
`define DIV_CODE_16 4'h3
`define DIV_CODE_32 4'h4
`define DIV_CODE_64 4'h5
`define DIV_CODE_6  4'h8
`define DIV_CODE_10 4'h9
`define DIV_CODE_12 4'hA
`define DIV_CODE_24 4'hB
`define DIV_CODE_48 4'hC
`define RATIO_W     7
`define RATIO_NONE  7'h01

// Protected write window in instructions
`define CCP_WINDOW  3'h4
`define CCP_ZERO    3'h0
`define CCP_STEP    3'h1

`endif

// File: design/peripheral_prescaler.v
// Divides main clock ticks into peripheral clock ticks
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_defines.vh"

module peripheral_prescaler (
    input wire sys_clk_in,
    input wire nrst_in,
    input wire main_tick_in,
    input wire prescale_enable_in,
    input wire [3:0] divider_field_in,
    output reg periph_tick_out
);

    function [`RATIO_W-1:0] ratio_of;
        input [3:0] code;
        begin
            case (code)
                `DIV_CODE_2: ratio_of = 7'h02;
                `DIV_CODE_4: ratio_of = 7'h04;
                `DIV_CODE_8: ratio_of = 7'h08;
                `DIV_CODE_16: ratio_of = 7'h10;
                `DIV_CODE_32: ratio_of = 7'h20;
                `DIV_CODE_64: ratio_of = 7'h40;
                `DIV_CODE_6: ratio_of = 7'h06;
                `DIV_CODE_10: ratio_of = 7'h0A;
                `DIV_CODE_12: ratio_of = 7'h0C;
                `DIV_CODE_24: ratio_of = 7'h18;
                `DIV_CODE_48: ratio_of = 7'h30;
                default: ratio_of = `RATIO_NONE;
            endcase
        end
    endfunction

    reg [`RATIO_W-1:0] count_q;
    wire [`RATIO_W-1:0] last_w = ratio_of(divider_field_in) - `RATIO_NONE;

    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_q <= {`RATIO_W{1'b0}};
            periph_tick_out <= 1'b0;
        end else if (!main_tick_in) begin
            periph_tick_out <= 1'b0;
        end else if (!prescale_enable_in) begin
            count_q <= {`RATIO_W{1'b0}};
            periph_tick_out <= 1'b1;
        end else if (count_q >= last_w) begin
            // Compare with >= so a smaller ratio written at run time takes effect at once
            count_q <= {`RATIO_W{1'b0}};
            periph_tick_out <= 1'b1;
        end else begin
            count_q <= count_q + `RATIO_NONE;
            periph_tick_out <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// File: design/main_clock_select_prescale.v
// Main clock source select, prescaler control, lock and status registers
// Overview of operation
// - Clock-out enable set toggles the clock output pin on each peripheral clock tick.
// - During sleep the clock pin stays quiet unless a peripheral still uses the clock.
// - Select field picks fast, ultra-low-power, crystal or external clock as main clock.
// - With prescale on, divider codes give ratios 2..64 and 6..48; others reserved.
// - Divider field may be rewritten at run time, changing peripheral clock rate.
// - Prescale off passes the main clock undivided, whatever the divider field holds.
// - Prescaler register resets to 0x11: enabled, divide by six.
// - Source register resets to 0x00: fast oscillator, clock pin off.
// - Lock bit blocks writes to source, prescaler and current source calibration.
// - Once locked, the lock register is inaccessible until the next reset.
// - Lock bit is loaded from the fuse calibration lock in the first cycle after reset release.
// - External started bit reads one after the external clock has started, only while it is requested.
// - Stable flags for crystal, ultra-low-power and fast oscillator show stability.
// - A stable flag shows only while its oscillator is requested.
// - Switching flag is high while a source change waits for the new source.
// - Status register is read only and resets to 0x00.
// - Protected writes count only within four instructions after the unlock key.
// - Protected writes without the unlock sequence leave the register unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_defines.vh"

module main_clock_select_prescale (
    input wire sys_clk_in,
    input wire nrst_in,
    input wire [4:0] addr_in,
    input wire wr_en_in,
    input wire [7:0] wr_data_in,
    input wire rd_en_in,
    output reg [7:0] rd_data_out,
    input wire unlock_key_in,
    input wire instr_retire_in,
    input wire fuse_osc_lock_in,
    input wire [6:0] fuse_freq_trim_in,
    input wire [3:0] fuse_temp_trim_in,
    input wire [3:0] osc_tick_in,
    input wire [3:0] osc_stable_in,
    input wire [3:0] module_request_in,
    input wire sleep_in,
    input wire periph_uses_clock_in,
    output reg main_tick_out,
    output wire periph_tick_out,
    output reg clock_pin_out,
    output reg clock_pin_oe_n_out,
    output reg [1:0] active_source_out,
    output reg [6:0] freq_trim_out,
    output reg [3:0] temp_trim_out,
    output wire [3:0] run_standby_out,
    output wire crystal_enable_out
);

    function div_code_valid;
        input [3:0] code;
        begin
            case (code)
                `DIV_CODE_2, `DIV_CODE_4, `DIV_CODE_8, `DIV_CODE_16, `DIV_CODE_32, `DIV_CODE_64,
                `DIV_CODE_6, `DIV_CODE_10, `DIV_CODE_12, `DIV_CODE_24, `DIV_CODE_48: div_code_valid = 1'b1;
                default: div_code_valid = 1'b0;
            endcase
        end
    endfunction

    reg [7:0] main_source_ctrl_q;
    reg [7:0] peripheral_prescale_ctrl_q;
    reg lock_q;
    reg fuse_lock_q;
    reg [7:0] main_clock_state_q;
    reg [7:0] fast_osc_ctrl_q;
    reg [7:0] slow_osc_ctrl_q;
    reg [7:0] crystal_osc_ctrl_q;
    reg [1:0] target_source_q;
    reg switching_q;
    reg fuse_loaded_q;
    reg [2:0] ccp_window_q;
    reg [3:0] reported_w;
    reg [3:0] requested_w;
    reg [7:0] rd_d;

    wire [1:0] sel_w = main_source_ctrl_q[`SEL_MSB:`SEL_LSB];
    wire ccp_open_w = (ccp_window_q != `CCP_ZERO);
    wire prot_wr_w = wr_en_in && ccp_open_w;
    wire main_locked_w = lock_q;
    // Calibration belongs to the fast oscillator, so the lock bit only guards it while it is the main clock
    wire cal_locked_w = fuse_lock_q || (lock_q && active_source_out == `SRC_FAST);
    wire [3:0] new_div_w = wr_data_in[`DIV_MSB:`DIV_LSB];
    wire crystal_held_w = crystal_osc_ctrl_q[`BIT_XTAL_ENABLE] || main_clock_state_q[`STABLE_LSB + 2];

    assign run_standby_out = {1'b0, crystal_osc_ctrl_q[`BIT_RUN_STANDBY],
                              slow_osc_ctrl_q[`BIT_RUN_STANDBY], fast_osc_ctrl_q[`BIT_RUN_STANDBY]};
    assign crystal_enable_out = crystal_osc_ctrl_q[`BIT_XTAL_ENABLE];

    // Unlock window: opened by the key, closed after four instructions or one protected write
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ccp_window_q <= `CCP_ZERO;
        end else if (unlock_key_in) begin
            ccp_window_q <= `CCP_WINDOW;
        end else if (wr_en_in && ccp_open_w) begin
            ccp_window_q <= `CCP_ZERO;
        end else if (instr_retire_in && ccp_open_w) begin
            ccp_window_q <= ccp_window_q - `CCP_STEP;
        end
    end

    // Fuse values are captured in the first cycle after reset release, not by the reset itself
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fuse_loaded_q <= 1'b0;
        end else begin
            fuse_loaded_q <= 1'b1;
        end
    end

    // Main source and prescaler registers
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            main_source_ctrl_q <= `RST_MAIN_SOURCE_CTRL;
            peripheral_prescale_ctrl_q <= `RST_PRESCALE_CTRL;
        end else if (prot_wr_w && !main_locked_w) begin
            if (addr_in == `OFS_MAIN_SOURCE_CTRL) begin
                main_source_ctrl_q <= wr_data_in & `MASK_MAIN_SOURCE;
            end
            if (addr_in == `OFS_PRESCALE_CTRL) begin
                if (div_code_valid(new_div_w)) begin
                    peripheral_prescale_ctrl_q <= wr_data_in & `MASK_PRESCALE;
                end else begin
                    // Keep the old ratio but still take the enable bit
                    peripheral_prescale_ctrl_q[`BIT_PRESCALE_EN] <= wr_data_in[`BIT_PRESCALE_EN];
                end
            end
        end
    end

    // Lock bit and fuse lock copy
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lock_q <= 1'b0;
            fuse_lock_q <= 1'b0;
        end else if (!fuse_loaded_q) begin
            lock_q <= fuse_osc_lock_in;
            fuse_lock_q <= fuse_osc_lock_in;
        end else if (prot_wr_w && !lock_q && addr_in == `OFS_SETTINGS_LOCK) begin
            // Only a reset clears it again
            lock_q <= wr_data_in[`BIT_LOCK];
        end
    end

    // Calibration trims
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            freq_trim_out <= 7'h00;
            temp_trim_out <= 4'h0;
        end else if (!fuse_loaded_q) begin
            freq_trim_out <= fuse_freq_trim_in;
            temp_trim_out <= fuse_temp_trim_in;
        end else if (prot_wr_w && !cal_locked_w) begin
            if (addr_in == `OFS_FAST_OSC_FREQ_TRIM) begin
                freq_trim_out <= wr_data_in[6:0];
            end
            if (addr_in == `OFS_FAST_OSC_TEMP_TRIM) begin
                temp_trim_out <= wr_data_in[3:0];
            end
        end
    end

    // Oscillator control registers
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fast_osc_ctrl_q <= `RST_OSC_CTRL;
            slow_osc_ctrl_q <= `RST_OSC_CTRL;
            crystal_osc_ctrl_q <= `RST_OSC_CTRL;
        end else if (prot_wr_w) begin
            if (addr_in == `OFS_FAST_OSC_CTRL) begin
                fast_osc_ctrl_q <= wr_data_in & `MASK_RUN_STANDBY;
            end
            if (addr_in == `OFS_SLOW_OSC_CTRL) begin
                slow_osc_ctrl_q <= wr_data_in & `MASK_RUN_STANDBY;
            end
            if (addr_in == `OFS_CRYSTAL_OSC_CTRL) begin
                // Type and start-up fields freeze while the crystal is enabled or still stable
                if (crystal_held_w) begin
                    crystal_osc_ctrl_q <= (crystal_osc_ctrl_q & ~`MASK_XTAL_LOCKED) |
                                          (wr_data_in & `MASK_XTAL_LOCKED);
                end else begin
                    crystal_osc_ctrl_q <= wr_data_in & `MASK_XTAL_CTRL;
                end
            end
        end
    end

    // Source switch: the old source keeps running until the new one reports stable
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            target_source_q <= `SRC_FAST;
            active_source_out <= `SRC_FAST;
            switching_q <= 1'b0;
        end else begin
            target_source_q <= sel_w;
            if (sel_w != active_source_out) begin
                if (osc_stable_in[sel_w] && target_source_q == sel_w) begin
                    active_source_out <= sel_w;
                    switching_q <= 1'b0;
                end else begin
                    switching_q <= 1'b1;
                end
            end else begin
                switching_q <= 1'b0;
            end
        end
    end

    // Requests come from the active or pending main source and from other modules
    always @* begin
        requested_w = module_request_in;
        requested_w[active_source_out] = 1'b1;
        requested_w[sel_w] = 1'b1;
        requested_w[`SRC_CRYSTAL] = requested_w[`SRC_CRYSTAL] && crystal_osc_ctrl_q[`BIT_XTAL_ENABLE];
        reported_w = requested_w & osc_stable_in;
    end

    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            main_clock_state_q <= `RST_CLOCK_STATE;
        end else begin
            main_clock_state_q <= {reported_w, 3'h0, switching_q};
        end
    end

    // Main clock tick from the active source
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            main_tick_out <= 1'b0;
        end else begin
            main_tick_out <= osc_tick_in[active_source_out];
        end
    end

    peripheral_prescaler u_prescaler (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .main_tick_in(main_tick_out),
        .prescale_enable_in(peripheral_prescale_ctrl_q[`BIT_PRESCALE_EN]),
        .divider_field_in(peripheral_prescale_ctrl_q[`DIV_MSB:`DIV_LSB]),
        .periph_tick_out(periph_tick_out)
    );

    // Clock pin toggles on each peripheral clock tick; sleep parks it low unless the clock is still in use
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clock_pin_out <= 1'b0;
            clock_pin_oe_n_out <= 1'b1;
        end else begin
            clock_pin_oe_n_out <= ~main_source_ctrl_q[`BIT_CLOCK_PIN_EN];
            if (!main_source_ctrl_q[`BIT_CLOCK_PIN_EN]) begin
                clock_pin_out <= 1'b0;
            end else if (sleep_in && !periph_uses_clock_in) begin
                clock_pin_out <= 1'b0;
            end else if (periph_tick_out) begin
                clock_pin_out <= ~clock_pin_out;
            end
        end
    end

    // Read mux; unmapped offsets and the locked lock register read zero
    always @* begin
        rd_d = 8'h00;
        case (addr_in)
            `OFS_MAIN_SOURCE_CTRL: rd_d = main_source_ctrl_q;
            `OFS_PRESCALE_CTRL: rd_d = peripheral_prescale_ctrl_q;
            `OFS_SETTINGS_LOCK: rd_d = {7'h00, 1'b0};
            `OFS_CLOCK_STATE: rd_d = main_clock_state_q;
            `OFS_FAST_OSC_CTRL: rd_d = fast_osc_ctrl_q;
            `OFS_FAST_OSC_FREQ_TRIM: rd_d = {1'b0, freq_trim_out};
            `OFS_FAST_OSC_TEMP_TRIM: rd_d = {fuse_lock_q, 3'h0, temp_trim_out};
            `OFS_SLOW_OSC_CTRL: rd_d = slow_osc_ctrl_q;
            `OFS_CRYSTAL_OSC_CTRL: rd_d = crystal_osc_ctrl_q;
            default: rd_d = 8'h00;
        endcase
        if (addr_in == `OFS_SETTINGS_LOCK && !lock_q) begin
            rd_d = {7'h00, lock_q};
        end
    end

    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_en_in) begin
            rd_data_out <= rd_d;
        end
    end

endmodule
`default_nettype wire

// File: testbench/main_clock_select_prescale_properties.sv
// Port-level checks for the main clock controller
`timescale 1ns/1ps
`default_nettype none
module main_clock_select_prescale_properties (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [4:0] addr_in,
    input wire logic rd_en_in,
    input wire logic [7:0] rd_data_out,
    input wire logic [6:0] fuse_freq_trim_in,
    input wire logic [3:0] fuse_temp_trim_in,
    input wire logic [3:0] osc_tick_in,
    input wire logic [3:0] osc_stable_in,
    input wire logic sleep_in,
    input wire logic periph_uses_clock_in,
    input wire logic main_tick_out,
    input wire logic periph_tick_out,
    input wire logic clock_pin_out,
    input wire logic [1:0] active_source_out,
    input wire logic [6:0] freq_trim_out,
    input wire logic [3:0] temp_trim_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    wire sel_tick = osc_tick_in[active_source_out];
    wire quiet = sleep_in && !periph_uses_clock_in;
    wire st_rd = rd_en_in && addr_in == 5'h03;
    a_main_tick_source: assert property (1 |=> main_tick_out == $past(sel_tick))
        else $error("main tick does not follow the active source");
    a_periph_from_main: assert property (periph_tick_out |-> $past(main_tick_out))
        else $error("peripheral tick without a main tick");
    a_pin_sleep_quiet: assert property (quiet ##1 quiet |=> !clock_pin_out)
        else $error("clock pin active during sleep");
    a_pin_toggle_tick: assert property ($rose(clock_pin_out) |-> $past(periph_tick_out) || $past(periph_tick_out, 2))
        else $error("clock pin rose without a peripheral tick");
    a_status_spare_zero: assert property (st_rd |=> rd_data_out[3:1] == 3'h0)
        else $error("status spare bits not zero");
    a_fast_flag_low: assert property (!osc_stable_in[0] ##1 (!osc_stable_in[0] && st_rd) |=> !rd_data_out[4])
        else $error("fast flag set while not stable");
    a_ext_flag_low: assert property (!osc_stable_in[3] ##1 (!osc_stable_in[3] && st_rd) |=> !rd_data_out[7])
        else $error("external started bit set too early");
    a_read_data_hold: assert property (!rd_en_in |=> $stable(rd_data_out))
        else $error("read data changed without a read");
    a_switch_on_stable: assert property ($changed(active_source_out) |-> (($past(osc_stable_in) >> active_source_out) & 4'h1) == 4'h1)
        else $error("source switched before the new source was stable");
    a_trim_fuse_load: assert property ($rose(nrst_in) |-> ##[1:2] freq_trim_out == fuse_freq_trim_in && temp_trim_out == fuse_temp_trim_in)
        else $error("trims not loaded from fuses");
    c_switch: cover property ($changed(active_source_out));
    c_pin: cover property ($rose(clock_pin_out));
    c_status: cover property (st_rd);
endmodule
bind main_clock_select_prescale main_clock_select_prescale_properties main_clock_select_prescale_properties_i (
    .sys_clk_in, .nrst_in, .addr_in, .rd_en_in, .rd_data_out, .fuse_freq_trim_in, .fuse_temp_trim_in,
    .osc_tick_in, .osc_stable_in, .sleep_in, .periph_uses_clock_in, .main_tick_out, .periph_tick_out,
    .clock_pin_out, .active_source_out, .freq_trim_out, .temp_trim_out);
`default_nettype wire

// File: testbench/tb_main_clock_select_prescale.sv
// Self-checking bench for the main clock controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(8'(g), 8'(e))
module tb_main_clock_select_prescale;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [4:0] addr_in = 5'h00;
    logic wr_en_in = 1'b0;
    logic [7:0] wr_data_in = 8'h00;
    logic rd_en_in = 1'b0;
    logic unlock_key_in = 1'b0;
    logic instr_retire_in = 1'b0;
    logic fuse_osc_lock_in = 1'b0;
    logic [6:0] fuse_freq_trim_in = 7'h35;
    logic [3:0] fuse_temp_trim_in = 4'h9;
    logic [3:0] osc_tick_in = 4'hF;
    logic [3:0] osc_stable_in = 4'h0;
    logic [3:0] module_request_in = 4'h0;
    logic sleep_in = 1'b0;
    logic periph_uses_clock_in = 1'b0;
    wire [7:0] rd_data_out;
    wire main_tick_out, periph_tick_out, clock_pin_out, clock_pin_oe_n_out, crystal_enable_out;
    wire [1:0] active_source_out;
    wire [6:0] freq_trim_out;
    wire [3:0] temp_trim_out, run_standby_out;
    integer fail_count = 0;
    integer checks_done = 0;
    integer p, i;
    logic [7:0] d;
    logic [3:0] c;
    byte unsigned ratio [0:10] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
    main_clock_select_prescale main_clock_select_prescale_i (.sys_clk_in, .nrst_in, .addr_in, .wr_en_in,
        .wr_data_in, .rd_en_in, .rd_data_out, .unlock_key_in, .instr_retire_in, .fuse_osc_lock_in,
        .fuse_freq_trim_in, .fuse_temp_trim_in, .osc_tick_in, .osc_stable_in, .module_request_in, .sleep_in,
        .periph_uses_clock_in, .main_tick_out, .periph_tick_out, .clock_pin_out, .clock_pin_oe_n_out,
        .active_source_out, .freq_trim_out, .temp_trim_out, .run_standby_out, .crystal_enable_out);
    always #5 sys_clk_in = ~sys_clk_in;
    task final_report;
        $display("Checks %0d, errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task check(input logic [7:0] g, input logic [7:0] e);
        checks_done = checks_done + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task reset(input logic fuse);
        @(negedge sys_clk_in);
        nrst_in = 1'b0;
        fuse_osc_lock_in = fuse;
        repeat (5) @(negedge sys_clk_in);
        nrst_in = 1'b1;
        repeat (2) @(negedge sys_clk_in);
    endtask
    task rd(input logic [4:0] a);
        @(negedge sys_clk_in);
        rd_en_in = 1'b1;
        addr_in = a;
        @(negedge sys_clk_in);
        rd_en_in = 1'b0;
        d = rd_data_out;
    endtask
    // Key opens the window, each retired instruction shrinks it
    task wr(input logic [4:0] a, input logic [7:0] v, input integer key, input integer retires);
        integer k;
        if (key != 0) begin
            @(negedge sys_clk_in);
            unlock_key_in = 1'b1;
            @(negedge sys_clk_in);
            unlock_key_in = 1'b0;
        end
        for (k = 0; k < retires; k = k + 1) begin
            @(negedge sys_clk_in);
            instr_retire_in = 1'b1;
            @(negedge sys_clk_in);
            instr_retire_in = 1'b0;
        end
        @(negedge sys_clk_in);
        wr_en_in = 1'b1;
        addr_in = a;
        wr_data_in = v;
        @(negedge sys_clk_in);
        wr_en_in = 1'b0;
    endtask
    // First gap may be partial after a divider change, so keep the last
    task period;
        integer k;
        for (k = 0; k < 3; k = k + 1) begin
            p = 0;
            do begin
                @(negedge sys_clk_in);
                p = p + 1;
                if (p > 300) begin
                    `CHK(8'h00, 8'h01);
                    final_report;
                end
            end while (periph_tick_out !== 1'b1);
        end
    endtask
    task toggles(input integer cycles, input integer want);
        integer k, t;
        logic last;
        t = 0;
        @(negedge sys_clk_in);
        last = clock_pin_out;
        for (k = 0; k < cycles; k = k + 1) begin
            @(negedge sys_clk_in);
            if (clock_pin_out !== last) t = t + 1;
            last = clock_pin_out;
        end
        `CHK(t, want);
    endtask
    task s_reset;
        rd(5'h00);
        `CHK(d, 8'h00);
        rd(5'h01);
        `CHK(d, 8'h11);
        rd(5'h03);
        `CHK(d, 8'h00);
        rd(5'h02);
        `CHK(d, 8'h00);
        period;
        `CHK(p, 6);
    endtask
    task s_protect;
        wr(5'h01, 8'h03, 0, 0);
        rd(5'h01);
        `CHK(d, 8'h11);
        wr(5'h01, 8'h03, 1, 4);
        rd(5'h01);
        `CHK(d, 8'h11);
        wr(5'h01, 8'h03, 1, 3);
        rd(5'h01);
        `CHK(d, 8'h03);
        period;
        `CHK(p, 4);
        wr(5'h01, 8'h11, 1, 0);
        wr(5'h01, 8'h05, 0, 0);
        rd(5'h01);
        `CHK(d, 8'h11);
    endtask
    task s_divide;
        for (i = 0; i < 11; i = i + 1) begin
            c = 4'((i < 6) ? i : i + 2);
            wr(5'h01, {3'h0, c, 1'b1}, 1, 0);
            rd(5'h01);
            `CHK(d, {3'h0, c, 1'b1});
            period;
            `CHK(p, ratio[i]);
        end
        wr(5'h01, 8'h1B, 1, 0);
        rd(5'h01);
        `CHK(d, 8'h19);
        period;
        `CHK(p, 48);
        // Enable off, divider code set to sixteen
        wr(5'h01, 8'h06, 1, 0);
        period;
        `CHK(p, 1);
    endtask
    task s_source;
        osc_stable_in = 4'hF;
        for (i = 1; i < 5; i = i + 1) begin
            wr(5'h00, 8'(i % 4), 1, 0);
            repeat (4) @(negedge sys_clk_in);
            `CHK(active_source_out, i % 4);
        end
    endtask
    task s_switch;
        osc_stable_in = 4'h1;
        wr(5'h00, 8'h03, 1, 0);
        repeat (3) @(negedge sys_clk_in);
        rd(5'h03);
        `CHK(d[0], 1'b1);
        `CHK(active_source_out, 2'h0);
        osc_stable_in = 4'h9;
        repeat (4) @(negedge sys_clk_in);
        `CHK(active_source_out, 2'h3);
        rd(5'h03);
        `CHK(d[0], 1'b0);
    endtask
    task s_status;
        osc_stable_in = 4'hF;
        // Run-in-standby alone must not make the slow flag show
        wr(5'h18, 8'h02, 1, 0);
        `CHK(run_standby_out, 4'h2);
        repeat (3) @(negedge sys_clk_in);
        rd(5'h03);
        `CHK(d, 8'h80);
        module_request_in = 4'hF;
        wr(5'h1C, 8'h01, 1, 0);
        `CHK(crystal_enable_out, 1'b1);
        wr(5'h03, 8'h00, 1, 0);
        repeat (3) @(negedge sys_clk_in);
        rd(5'h03);
        `CHK(d, 8'hF0);
    endtask
    task s_pin;
        wr(5'h00, 8'h83, 1, 0);
        repeat (2) @(negedge sys_clk_in);
        `CHK(clock_pin_oe_n_out, 1'b0);
        toggles(16, 16);
        sleep_in = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        toggles(8, 0);
        periph_uses_clock_in = 1'b1;
        toggles(8, 8);
        sleep_in = 1'b0;
        periph_uses_clock_in = 1'b0;
    endtask
    task s_lock;
        wr(5'h02, 8'h01, 1, 0);
        rd(5'h02);
        `CHK(d, 8'h00);
        wr(5'h01, 8'h11, 1, 0);
        rd(5'h01);
        `CHK(d, 8'h06);
        wr(5'h00, 8'h00, 1, 0);
        rd(5'h00);
        `CHK(d, 8'h83);
        // Active source is not the fast oscillator, so its trim stays writable
        wr(5'h11, 8'h12, 1, 0);
        `CHK(freq_trim_out, 7'h12);
        wr(5'h02, 8'h00, 1, 0);
        wr(5'h01, 8'h11, 1, 0);
        rd(5'h01);
        `CHK(d, 8'h06);
    endtask
    task s_fuse;
        reset(1'b1);
        wr(5'h01, 8'h03, 1, 0);
        rd(5'h01);
        `CHK(d, 8'h11);
        wr(5'h11, 8'h12, 1, 0);
        `CHK(freq_trim_out, 7'h35);
    endtask
    initial begin
        reset(1'b0);
        s_reset;
        s_protect;
        s_divide;
        s_source;
        s_switch;
        s_status;
        s_pin;
        s_lock;
        s_fuse;
        final_report;
    end
endmodule
`default_nettype wire
